/* File: common/pcp_pkg.sv */
// constants shared by the programmer control command parser
package pcp_pkg;
	localparam int CLK_HZ = 250_000_000;
	localparam int ADDR_W = 4;

	// ******************************************************
	// register map and fields
	// ******************************************************
	localparam logic [3:0] OFF_CMD = 4'h0;
	localparam logic [3:0] OFF_RESP = 4'h4;
	localparam logic [3:0] OFF_STAT = 4'h8;
	localparam logic [3:0] OFF_DUMP = 4'hC;
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_OPT_LSB = 4;
	localparam int RESP_VAL_LSB = 8;
	localparam int RESP_BUSY_BIT = 31;

	// ******************************************************
	// commands, options and responses
	// ******************************************************
	localparam logic [3:0] OP_AUTOCON = 4'h1;
	localparam logic [3:0] OP_RATE = 4'h2;
	localparam logic [3:0] OP_CLEAR = 4'h3;
	localparam logic [3:0] OP_CONF = 4'h4;
	localparam logic [3:0] OP_OPEN = 4'h5;
	localparam logic [3:0] OP_CLOSE = 4'h6;
	localparam logic [3:0] OP_TARGET = 4'h7;
	localparam logic [3:0] OP_ERASE_PROG = 4'h8;
	localparam logic [3:0] OPT_NONE = 4'h0;
	localparam logic [3:0] OPT_ON = 4'h1;
	localparam logic [3:0] OPT_OFF = 4'h2;
	localparam logic [3:0] OPT_GET = 4'h1;
	localparam logic [3:0] OPT_9600 = 4'h2;
	localparam logic [3:0] OPT_115200 = 4'h6;
	localparam logic [3:0] RK_OK = 4'h0;
	localparam logic [3:0] RK_ERR = 4'h1;
	localparam logic [3:0] RK_AUTO_ON = 4'h2;
	localparam logic [3:0] RK_AUTO_OFF = 4'h3;
	localparam logic [3:0] RK_RATE = 4'h4;
	localparam logic [3:0] RK_USB_HIGH_SPEED_REPORT = 4'h5;
	localparam logic [3:0] RK_USB_FULL_SPEED_REPORT = 4'h6;
	localparam logic [19:0] USB_HIGH_SPEED_REPORT_VERSION = 20'h00020;
	localparam logic [19:0] USB_FULL_SPEED_REPORT_VERSION = 20'h00011;

	// ******************************************************
	// serial rates and target operations
	// ******************************************************
	localparam logic [2:0] RC_9600 = 3'h0;
	localparam logic [2:0] RC_19200 = 3'h1;
	localparam logic [2:0] RC_38400 = 3'h2;
	localparam logic [2:0] RC_57600 = 3'h3;
	localparam logic [2:0] RC_115200 = 3'h4;
	localparam logic [2:0] RC_RESET = RC_9600;
	localparam logic [1:0] TOP_OPEN = 2'h0;
	localparam logic [1:0] TOP_CMD = 2'h1;
	localparam logic [1:0] TOP_ERASE_PROG = 2'h2;
	localparam logic [1:0] TOP_CLOSE = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	function automatic logic [19:0] rate_bps(input logic [2:0] rc);
		unique case (rc)
			RC_19200: rate_bps = 20'h04B00;
			RC_38400: rate_bps = 20'h09600;
			RC_57600: rate_bps = 20'h0E100;
			RC_115200: rate_bps = 20'h1C200;
			default: rate_bps = 20'h02580;
		endcase
	endfunction

	// clock cycles per serial bit
	function automatic logic [15:0] rate_div(input logic [2:0] rc);
		rate_div = 16'(CLK_HZ / int'(rate_bps(rc)));
	endfunction
endpackage

/* File: common/pcp_seq_if.sv */
// job handshake between the command decoder and the target sequencer
`timescale 1ns/1ps
interface pcp_seq_if;
	logic start;
	logic do_open;
	logic do_cmd;
	logic do_close;
	logic is_ep;
	logic busy;
	logic done;
	logic fail;
	modport ctl (output start, do_open, do_cmd, do_close, is_ep, input busy, done, fail);
	modport seq (input start, do_open, do_cmd, do_close, is_ep, output busy, done, fail);
endinterface

/* File: hdl/pcp_seq.sv */
// target sequencer: open, command and close steps toward the target engine
`timescale 1ns/1ps
module pcp_seq (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	pcp_seq_if.seq sq,
	output logic tgt_req,
	output logic [1:0] tgt_op,
	input wire logic tgt_done,
	input wire logic tgt_fail
);
	typedef enum logic [1:0] {S_IDLE, S_OPEN, S_CMD, S_CLOSE} pcp_state_type;
	pcp_state_type state_q;
	pcp_state_type after_open, after_cmd, first_step;
	logic issued_q, busy_q, done_q, fail_q, req_q;
	logic [1:0] op_q, step_op;

	assign first_step = sq.do_open ? S_OPEN : (sq.do_cmd ? S_CMD : S_CLOSE);
	assign after_open = sq.do_cmd ? S_CMD : (sq.do_close ? S_CLOSE : S_IDLE);
	assign after_cmd = sq.do_close ? S_CLOSE : S_IDLE;
	assign step_op = (state_q == S_OPEN) ? pcp_pkg::TOP_OPEN :
		(state_q == S_CLOSE) ? pcp_pkg::TOP_CLOSE :
		(sq.is_ep ? pcp_pkg::TOP_ERASE_PROG : pcp_pkg::TOP_CMD);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= S_IDLE;
			issued_q <= 1'b0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			fail_q <= 1'b0;
			req_q <= 1'b0;
			op_q <= pcp_pkg::TOP_OPEN;
		end else if (ce) begin
			req_q <= 1'b0;
			done_q <= 1'b0;
			// busy spans the done cycle so no new job overlaps the result
			if (done_q) begin
				busy_q <= 1'b0;
			end
			unique case (state_q)
				S_IDLE: begin
					if (sq.start) begin
						state_q <= first_step;
						busy_q <= 1'b1;
						fail_q <= 1'b0;
						issued_q <= 1'b0;
					end
				end
				default: begin
					if (!issued_q) begin
						req_q <= 1'b1;
						op_q <= step_op;
						issued_q <= 1'b1;
					end else if (tgt_done) begin
						issued_q <= 1'b0;
						fail_q <= fail_q | tgt_fail;
						// a failed open skips command and close
						if (state_q == S_OPEN && !tgt_fail) begin
							state_q <= after_open;
						end else if (state_q == S_CMD) begin
							state_q <= after_cmd;
						end else begin
							state_q <= S_IDLE;
						end
						if ((state_q == S_OPEN && (tgt_fail || after_open == S_IDLE)) ||
							(state_q == S_CMD && after_cmd == S_IDLE) || state_q == S_CLOSE) begin
							done_q <= 1'b1;
						end
					end
				end
			endcase
		end
	end

	assign sq.busy = busy_q;
	assign sq.done = done_q;
	assign sq.fail = fail_q;
	assign tgt_req = req_q;
	assign tgt_op = op_q;
endmodule

/* File: hdl/pcp_dump.sv */
// information dump walker: stored data words, then the settings word
`timescale 1ns/1ps
module pcp_dump #(
	parameter int DEPTH = 16,
	parameter int IAW = $clog2(DEPTH)
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic restart,
	input wire logic advance,
	input wire logic [31:0] settings,
	input wire logic [31:0] info_data,
	output logic [IAW-1:0] info_addr,
	output logic [31:0] word
);
	localparam int CW = $clog2(DEPTH + 2);
	localparam logic [CW-1:0] LAST = CW'(DEPTH);
	logic [CW-1:0] idx_q;

	if (DEPTH < 2 || DEPTH > 4096) begin : g_bad_depth
		$error("dump depth out of range");
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || (ce && restart)) begin
			idx_q <= '0;
		end else if (ce && advance && idx_q <= LAST) begin
			idx_q <= idx_q + CW'(1);
		end
	end

	// past the settings word the walk reads zero until restarted
	assign info_addr = idx_q[IAW-1:0];
	assign word = (idx_q < LAST) ? info_data : ((idx_q == LAST) ? settings : 32'h0000_0000);
endmodule

/* File: hdl/pcp_top.sv */
// programmer control command parser with an AXI4-Lite register port
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module pcp_top #(
	parameter int DUMP_DEPTH = 16,
	parameter int DUMP_AW = $clog2(DUMP_DEPTH)
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [pcp_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [pcp_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic usb_connected,
	input wire logic usb_high_speed,
	output logic tgt_req,
	output logic [1:0] tgt_op,
	input wire logic tgt_done,
	input wire logic tgt_fail,
	output logic pass_lamp,
	output logic fail_lamp,
	output logic remote_pass,
	output logic remote_fail,
	output logic [2:0] rate_code,
	output logic [15:0] baud_div,
	output logic [DUMP_AW-1:0] info_addr,
	input wire logic [31:0] info_data
);
	// ******************************************************
	// bus slave state
	// ******************************************************
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic aw_hold_q, w_hold_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] wdata_q, rdata_q;
	logic [3:0] wstrb_q;
	logic [pcp_pkg::ADDR_W-1:0] awaddr_q;
	logic auto_q, open_q, pass_q, fail_q, start_q;
	logic job_open_q, job_cmd_q, job_close_q, job_ep_q;
	logic [2:0] rate_q;
	logic [15:0] baud_q;
	logic [3:0] resp_kind_q;
	logic [19:0] resp_val_q;

	pcp_seq_if sq();

	wire aw_go = s_axi_awvalid & awready_q & ce;
	wire w_go = s_axi_wvalid & wready_q & ce;
	wire ar_go = s_axi_arvalid & arready_q & ce;
	wire wr_go = aw_hold_q & w_hold_q & ~bvalid_q & ce;
	wire sel_cmd = awaddr_q == pcp_pkg::OFF_CMD;
	wire cmd_go = wr_go & sel_cmd & wstrb_q[0] & ~sq.busy;
	wire wr_ok = sel_cmd & ~sq.busy;
	wire rd_mapped = s_axi_araddr == pcp_pkg::OFF_CMD || s_axi_araddr == pcp_pkg::OFF_RESP ||
		s_axi_araddr == pcp_pkg::OFF_STAT || s_axi_araddr == pcp_pkg::OFF_DUMP;

	// ******************************************************
	// command decode
	// ******************************************************
	wire [3:0] cmd_op = wdata_q[pcp_pkg::CMD_OP_LSB +: 4];
	wire [3:0] cmd_opt = wdata_q[pcp_pkg::CMD_OPT_LSB +: 4];
	wire is_autocon = cmd_op == pcp_pkg::OP_AUTOCON;
	wire is_rate = cmd_op == pcp_pkg::OP_RATE;
	wire is_clear = cmd_op == pcp_pkg::OP_CLEAR;
	wire is_conf = cmd_op == pcp_pkg::OP_CONF;
	wire is_open = cmd_op == pcp_pkg::OP_OPEN;
	wire is_close = cmd_op == pcp_pkg::OP_CLOSE;
	wire is_target = cmd_op == pcp_pkg::OP_TARGET;
	wire is_ep = cmd_op == pcp_pkg::OP_ERASE_PROG;
	wire known_op = cmd_op >= pcp_pkg::OP_AUTOCON && cmd_op <= pcp_pkg::OP_ERASE_PROG;
	wire opt_ok = is_autocon ? cmd_opt <= pcp_pkg::OPT_OFF :
		is_rate ? cmd_opt <= pcp_pkg::OPT_115200 :
		known_op && cmd_opt == pcp_pkg::OPT_NONE;
	wire good = cmd_go & opt_ok;
	wire bad = cmd_go & ~opt_ok;
	wire manual_block = good & is_target & ~auto_q & ~open_q;
	wire launch = good & (is_open | is_close | is_ep | (is_target & ~manual_block));
	wire j_open = is_open | is_ep | (is_target & auto_q);
	wire j_close = is_close | is_ep | (is_target & auto_q);
	wire rate_set = good & is_rate & cmd_opt >= pcp_pkg::OPT_9600;
	wire [2:0] new_rc = 3'(cmd_opt - pcp_pkg::OPT_9600);
	wire usb_query = good & is_rate & cmd_opt == pcp_pkg::OPT_NONE & usb_connected;
	wire [31:0] stat_word = {21'h000000, rate_q, 2'h0, usb_high_speed, usb_connected,
		fail_q, pass_q, open_q, auto_q};
	wire [31:0] resp_word = {sq.busy, 3'h0, resp_val_q, 4'h0, resp_kind_q};
	wire [31:0] dump_word;
	wire dump_adv = ar_go & s_axi_araddr == pcp_pkg::OFF_DUMP;
	wire [31:0] rd_sel = s_axi_araddr == pcp_pkg::OFF_CMD ? wdata_q :
		s_axi_araddr == pcp_pkg::OFF_RESP ? resp_word :
		s_axi_araddr == pcp_pkg::OFF_STAT ? stat_word :
		s_axi_araddr == pcp_pkg::OFF_DUMP ? dump_word : 32'h0000_0000;

	// ******************************************************
	// AXI4-Lite write channel
	// ******************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= pcp_pkg::RESP_OKAY;
			awaddr_q <= '0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else if (ce) begin
			if (aw_go) begin
				awready_q <= 1'b0;
				aw_hold_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (w_go) begin
				wready_q <= 1'b0;
				w_hold_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			// a command arriving while a target job runs is refused
			if (wr_go) begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_ok ? pcp_pkg::RESP_OKAY : pcp_pkg::RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end

	// ******************************************************
	// AXI4-Lite read channel
	// ******************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= pcp_pkg::RESP_OKAY;
		end else if (ce) begin
			if (ar_go) begin
				arready_q <= 1'b0;
				rvalid_q <= 1'b1;
				rdata_q <= rd_sel;
				rresp_q <= rd_mapped ? pcp_pkg::RESP_OKAY : pcp_pkg::RESP_SLVERR;
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
				arready_q <= 1'b1;
			end
		end
	end

	// ******************************************************
	// settings and response
	// ******************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			auto_q <= 1'b1;
			rate_q <= pcp_pkg::RC_RESET;
			baud_q <= pcp_pkg::rate_div(pcp_pkg::RC_RESET);
			resp_kind_q <= pcp_pkg::RK_OK;
			resp_val_q <= 20'h00000;
		end else if (ce) begin
			if (bad || manual_block) begin
				resp_kind_q <= pcp_pkg::RK_ERR;
				resp_val_q <= 20'h00000;
			end else if (good && is_autocon) begin
				if (cmd_opt == pcp_pkg::OPT_ON) begin
					auto_q <= 1'b1;
				end else if (cmd_opt == pcp_pkg::OPT_OFF) begin
					auto_q <= 1'b0;
				end
				resp_kind_q <= (cmd_opt == pcp_pkg::OPT_ON ||
					(cmd_opt == pcp_pkg::OPT_NONE && auto_q)) ?
					pcp_pkg::RK_AUTO_ON : pcp_pkg::RK_AUTO_OFF;
				resp_val_q <= 20'h00000;
			end else if (rate_set) begin
				// the host must then move its own port to the new rate
				rate_q <= new_rc;
				baud_q <= pcp_pkg::rate_div(new_rc);
				resp_kind_q <= pcp_pkg::RK_RATE;
				resp_val_q <= pcp_pkg::rate_bps(new_rc);
			end else if (usb_query) begin
				resp_kind_q <= usb_high_speed ? pcp_pkg::RK_USB_HIGH_SPEED_REPORT : pcp_pkg::RK_USB_FULL_SPEED_REPORT;
				resp_val_q <= usb_high_speed ? pcp_pkg::USB_HIGH_SPEED_REPORT_VERSION : pcp_pkg::USB_FULL_SPEED_REPORT_VERSION;
			end else if (good && is_rate) begin
				resp_kind_q <= pcp_pkg::RK_RATE;
				resp_val_q <= pcp_pkg::rate_bps(rate_q);
			end else if (good) begin
				resp_kind_q <= pcp_pkg::RK_OK;
				resp_val_q <= 20'h00000;
			end else if (sq.done) begin
				resp_kind_q <= sq.fail ? pcp_pkg::RK_ERR : pcp_pkg::RK_OK;
			end
		end
	end

	// ******************************************************
	// result lamps, connection state, job hand-off
	// ******************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pass_q <= 1'b0;
			fail_q <= 1'b0;
			open_q <= 1'b0;
		end else if (ce) begin
			if (good && is_clear) begin
				pass_q <= 1'b0;
				fail_q <= 1'b0;
			end else if (sq.done && job_cmd_q) begin
				pass_q <= ~sq.fail;
				fail_q <= sq.fail;
			end
			if (sq.done && job_close_q) begin
				open_q <= 1'b0;
			end else if (sq.done && job_open_q && !sq.fail) begin
				open_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			start_q <= 1'b0;
			job_open_q <= 1'b0;
			job_cmd_q <= 1'b0;
			job_close_q <= 1'b0;
			job_ep_q <= 1'b0;
		end else if (ce) begin
			start_q <= launch;
			if (launch) begin
				job_open_q <= j_open;
				job_cmd_q <= is_target | is_ep;
				job_close_q <= j_close;
				job_ep_q <= is_ep;
			end
		end
	end

	assign sq.start = start_q;
	assign sq.do_open = job_open_q;
	assign sq.do_cmd = job_cmd_q;
	assign sq.do_close = job_close_q;
	assign sq.is_ep = job_ep_q;

	pcp_seq u_seq (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.sq(sq),
		.tgt_req(tgt_req),
		.tgt_op(tgt_op),
		.tgt_done(tgt_done),
		.tgt_fail(tgt_fail)
	);

	// settings word carries the connection selection into the listing
	pcp_dump #(.DEPTH(DUMP_DEPTH), .IAW(DUMP_AW)) u_dump (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.restart(good & is_conf),
		.advance(dump_adv),
		.settings(stat_word),
		.info_data(info_data),
		.info_addr(info_addr),
		.word(dump_word)
	);

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign pass_lamp = pass_q;
	assign remote_pass = pass_q;
	assign fail_lamp = fail_q;
	assign remote_fail = fail_q;
	assign rate_code = rate_q;
	assign baud_div = baud_q;

	// ******************************************************
	// checks
	// ******************************************************
	auto_reset_a: assert property (@(posedge aclk) !aresetn |=> auto_q)
		else $error("connection selection not automatic after reset");
	rate_reset_a: assert property (@(posedge aclk) !aresetn |=>
		rate_q == pcp_pkg::RC_9600 && baud_div == pcp_pkg::rate_div(pcp_pkg::RC_9600))
		else $error("serial rate not 9600 after reset");
	auto_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
		good && is_target && auto_q |=> sq.start && sq.do_open && sq.do_cmd && sq.do_close)
		else $error("automatic target job lacks open or close");
	manual_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
		good && is_target && !auto_q && !open_q |=> resp_kind_q == pcp_pkg::RK_ERR && !start_q)
		else $error("target command ran without open in manual mode");
	auto_query_a: assert property (@(posedge aclk) disable iff (!aresetn)
		good && is_autocon && cmd_opt == pcp_pkg::OPT_NONE |=> auto_q == $past(auto_q) &&
		resp_kind_q == ($past(auto_q) ? pcp_pkg::RK_AUTO_ON : pcp_pkg::RK_AUTO_OFF))
		else $error("selection query changed or misreported mode");
	ep_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
		good && is_ep |=> start_q && sq.do_open && sq.do_close && sq.is_ep)
		else $error("erase-then-program without open and close");
	rate_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rate_set |=> rate_q == $past(new_rc) && baud_div == pcp_pkg::rate_div(rate_q))
		else $error("rate change not applied");
	usb_report_a: assert property (@(posedge aclk) disable iff (!aresetn)
		usb_query && usb_high_speed |=> resp_kind_q == pcp_pkg::RK_USB_HIGH_SPEED_REPORT &&
		resp_val_q == pcp_pkg::USB_HIGH_SPEED_REPORT_VERSION)
		else $error("high speed USB not reported as 2.0");
	clear_lamps_a: assert property (@(posedge aclk) disable iff (!aresetn)
		good && is_clear |=> !pass_lamp && !fail_lamp && !remote_pass && !remote_fail)
		else $error("clear left a result lamp on");
	reject_opt_a: assert property (@(posedge aclk) disable iff (!aresetn)
		bad |=> $stable(auto_q) && $stable(rate_q) && resp_kind_q == pcp_pkg::RK_ERR)
		else $error("bad option changed settings or gave no error");
endmodule

/* File: sim/pcp_tgt_model.sv */
// target engine model answering open, command and close steps
`timescale 1ns/1ps
module pcp_tgt_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic tgt_req,
	input wire logic [1:0] tgt_op,
	input wire logic [2:0] fail_op,
	input wire logic [3:0] delay,
	output logic tgt_done,
	output logic tgt_fail
);
	logic busy_q;
	logic [3:0] cnt_q;
	logic [1:0] op_q;
	// fail toggles outside done so a stale level is never trusted
	always_ff @(posedge aclk) begin
		tgt_done <= 1'b0;
		tgt_fail <= ~tgt_fail;
		if (!aresetn) begin
			busy_q <= 1'b0;
			tgt_fail <= 1'b0;
		end else if (tgt_req) begin
			busy_q <= 1'b1;
			cnt_q <= delay;
			op_q <= tgt_op;
		end else if (busy_q && cnt_q == 4'h0) begin
			busy_q <= 1'b0;
			tgt_done <= 1'b1;
			tgt_fail <= ({1'b0, op_q} == fail_op);
		end else if (busy_q) begin
			cnt_q <= cnt_q - 4'h1;
		end
	end
endmodule

/* File: sim/programmer_control_command_parser_test.sv */
// self-checking bench for the programmer control command parser
`timescale 1ns/1ps
module programmer_control_command_parser_test;
	logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
	logic [pcp_pkg::ADDR_W-1:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
	logic [3:0] s_axi_wstrb = 4'hF, delay = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, info_data;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, usb_connected = 1'b0;
	logic usb_high_speed = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, tgt_req, tgt_done, tgt_fail;
	logic pass_lamp, fail_lamp, remote_pass, remote_fail;
	logic [1:0] s_axi_bresp, s_axi_rresp, tgt_op, info_addr;
	logic [2:0] rate_code, fail_op = 3'h4;
	logic [15:0] baud_div;
	logic [7:0] oplog = 8'h0;
	int n_mismatch = 0, comparisons = 0;
	int bps[5] = '{9600, 19200, 38400, 57600, 115200};

	pcp_top #(.DUMP_DEPTH(4)) dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.usb_connected, .usb_high_speed, .tgt_req, .tgt_op, .tgt_done, .tgt_fail,
		.pass_lamp, .fail_lamp, .remote_pass, .remote_fail, .rate_code, .baud_div,
		.info_addr, .info_data);
	pcp_tgt_model partner (.aclk, .aresetn, .tgt_req, .tgt_op, .fail_op, .delay,
		.tgt_done, .tgt_fail);
	assign info_data = 32'hD0000000 | 32'(info_addr);

	initial forever #2 aclk = ~aclk;
	always @(posedge aclk) if (tgt_req === 1'b1) oplog <= {oplog[5:0], tgt_op};

	// ******************************
	// bus cycles and comparison
	// ******************************
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 50);
		if (n >= 50) n_mismatch++;
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 50);
		if (n >= 50) n_mismatch++;
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// a poll that never sees busy drop counts as a hang
	task automatic cmdk(input logic [3:0] op, opt, k, output logic [31:0] rs);
		logic [1:0] r;
		int n;
		axw(pcp_pkg::OFF_CMD, {24'h0, opt, op}, r);
		chk("bresp", 32'(r), 32'(pcp_pkg::RESP_OKAY));
		n = 0;
		do begin
			axr(pcp_pkg::OFF_RESP, rs, r);
			n++;
		end while (rs[31] !== 1'b0 && n < 50);
		if (n >= 50) n_mismatch++;
		chk("kind", 32'(rs[3:0]), 32'(k));
	endtask

	function automatic logic [31:0] lamps();
		return {28'h0, pass_lamp, remote_pass, fail_lamp, remote_fail};
	endfunction

	// ******************************
	// scenarios
	// ******************************
	task automatic t_basic;
		logic [31:0] w;
		logic [1:0] r;
		axr(pcp_pkg::OFF_STAT, w, r);
		chk("stat", w & 32'h73D, 32'h1);
		chk("div", 32'(baud_div), 32'd26041);
		cmdk(pcp_pkg::OP_AUTOCON, pcp_pkg::OPT_NONE, pcp_pkg::RK_AUTO_ON, w);
		cmdk(pcp_pkg::OP_AUTOCON, pcp_pkg::OPT_OFF, pcp_pkg::RK_AUTO_OFF, w);
		cmdk(pcp_pkg::OP_AUTOCON, 4'h3, pcp_pkg::RK_ERR, w);
		cmdk(pcp_pkg::OP_AUTOCON, pcp_pkg::OPT_NONE, pcp_pkg::RK_AUTO_OFF, w);
		cmdk(pcp_pkg::OP_AUTOCON, pcp_pkg::OPT_ON, pcp_pkg::RK_AUTO_ON, w);
		axw(pcp_pkg::OFF_STAT, 32'h0, r);
		chk("ro", 32'(r), 32'(pcp_pkg::RESP_SLVERR));
	endtask

	task automatic t_target;
		logic [31:0] w;
		logic [7:0] s;
		cmdk(pcp_pkg::OP_TARGET, pcp_pkg::OPT_NONE, pcp_pkg::RK_OK, w);
		chk("auto ops", 32'(oplog[5:0]), 32'h07);
		chk("lamps", lamps(), 32'hC);
		delay <= 4'h9;
		cmdk(pcp_pkg::OP_AUTOCON, pcp_pkg::OPT_OFF, pcp_pkg::RK_AUTO_OFF, w);
		s = oplog;
		cmdk(pcp_pkg::OP_TARGET, pcp_pkg::OPT_NONE, pcp_pkg::RK_ERR, w);
		chk("no ops", 32'(oplog), 32'(s));
		cmdk(pcp_pkg::OP_OPEN, pcp_pkg::OPT_NONE, pcp_pkg::RK_OK, w);
		cmdk(pcp_pkg::OP_TARGET, pcp_pkg::OPT_NONE, pcp_pkg::RK_OK, w);
		cmdk(pcp_pkg::OP_TARGET, pcp_pkg::OPT_NONE, pcp_pkg::RK_OK, w);
		cmdk(pcp_pkg::OP_CLOSE, pcp_pkg::OPT_NONE, pcp_pkg::RK_OK, w);
		chk("manual ops", 32'(oplog), 32'h17);
		fail_op <= 3'h2;
		cmdk(pcp_pkg::OP_ERASE_PROG, pcp_pkg::OPT_NONE, pcp_pkg::RK_ERR, w);
		chk("ep ops", 32'(oplog[5:0]), 32'h0B);
		chk("lamps", lamps(), 32'h3);
		cmdk(pcp_pkg::OP_CLEAR, pcp_pkg::OPT_NONE, pcp_pkg::RK_OK, w);
		chk("lamps", lamps(), 32'h0);
	endtask

	task automatic t_rate;
		logic [31:0] w;
		for (int i = 0; i < 5; i++) begin
			cmdk(pcp_pkg::OP_RATE, 4'(i + 2), pcp_pkg::RK_RATE, w);
			chk("bps", 32'(w[27:8]), 32'(bps[i]));
			chk("rate", 32'(rate_code), 32'(i));
			// host side must adopt this divider before its next command
			chk("div", 32'(baud_div), 32'(250000000 / bps[i]));
		end
		cmdk(pcp_pkg::OP_RATE, pcp_pkg::OPT_NONE, pcp_pkg::RK_RATE, w);
		chk("bps", 32'(w[27:8]), 32'd115200);
		usb_connected <= 1'b1;
		usb_high_speed <= 1'b1;
		cmdk(pcp_pkg::OP_RATE, pcp_pkg::OPT_NONE, pcp_pkg::RK_USB_HIGH_SPEED_REPORT, w);
		chk("ver", 32'(w[27:8]), 32'h20);
		usb_high_speed <= 1'b0;
		cmdk(pcp_pkg::OP_RATE, pcp_pkg::OPT_NONE, pcp_pkg::RK_USB_FULL_SPEED_REPORT, w);
		chk("ver", 32'(w[27:8]), 32'h11);
		cmdk(pcp_pkg::OP_RATE, pcp_pkg::OPT_GET, pcp_pkg::RK_RATE, w);
		chk("bps", 32'(w[27:8]), 32'd115200);
		cmdk(pcp_pkg::OP_RATE, 4'h7, pcp_pkg::RK_ERR, w);
		chk("rate", 32'(rate_code), 32'h4);
	endtask

	task automatic t_dump;
		logic [31:0] w;
		logic [1:0] r;
		cmdk(pcp_pkg::OP_CONF, pcp_pkg::OPT_NONE, pcp_pkg::RK_OK, w);
		for (int i = 0; i < 4; i++) begin
			axr(pcp_pkg::OFF_DUMP, w, r);
			chk("dump", w, 32'hD0000000 | 32'(i));
		end
		axr(pcp_pkg::OFF_DUMP, w, r);
		chk("dump stat", w & 32'h73D, 32'h410);
		axr(pcp_pkg::OFF_DUMP, w, r);
		chk("dump end", w, 32'h0);
	endtask

	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_basic();
		t_target();
		t_rate();
		t_dump();
		complete_run();
	end

	// whole run is a few hundred cycles
	initial begin
		#40000;
		n_mismatch++;
		complete_run();
	end
endmodule
